/* core/lrc_top.sv */
// line rate limit calculator with its AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "lrc_defines.svh"
module lrc_top #(
    parameter int SEGS = 2,
    parameter logic [31:0] PIXEL_PROCESSING_RATE = 32'h2625_a000
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [5:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output lrc_pkg::lrc_resp_t S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [5:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output lrc_pkg::lrc_resp_t S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic LINE_START_O
);
    import lrc_pkg::*;

    logic [31:0] ctrl_q, exp_q, start_q, len_q, taps_q, lclk_q, period_q;
    logic [31:0] lim_q [4];
    logic [31:0] period_min_q, rate_q;
    logic valid_q, dirty_q, issued_q;
    lrc_state_t state_q;
    lrc_ctrl_t ctrl;

    // write channel holding
    logic aw_full_q, w_full_q;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] wmask;
    logic do_wr;
    logic wr_hit_cfg;
    logic wr_mapped, rd_mapped;

    assign ctrl = ctrl_q[4:0];
    assign S_AXI_AWREADY_O = !aw_full_q;
    assign S_AXI_WREADY_O = !w_full_q;
    assign do_wr = aw_full_q && w_full_q && !S_AXI_BVALID_O;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_mapped = awaddr_q[1:0] == 2'h0 && awaddr_q <= `LRC_OFS_STATUS;
    assign rd_mapped = S_AXI_ARADDR_I[1:0] == 2'h0 && S_AXI_ARADDR_I <= `LRC_OFS_STATUS;
    // a write to any setting other than the programmed period triggers a recompute
    assign wr_hit_cfg = do_wr && awaddr_q <= `LRC_OFS_LINK_CLK && awaddr_q[1:0] == 2'h0;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_q <= `LRC_RST_CTRL;
            exp_q <= `LRC_RST_EXPOSURE;
            start_q <= `LRC_RST_WIN_START;
            len_q <= `LRC_RST_WIN_LEN;
            taps_q <= `LRC_RST_TAPS;
            lclk_q <= `LRC_RST_LINK_CLK;
            period_q <= `LRC_RST_LINE_PERIOD;
        end else if (do_wr) begin
            unique case (awaddr_q)
                `LRC_OFS_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wmask) & 32'h0000_001f;
                `LRC_OFS_EXPOSURE: exp_q <= merge(exp_q, wdata_q, wmask);
                `LRC_OFS_WIN_START: start_q <= merge(start_q, wdata_q, wmask) & 32'h0000_1fff;
                `LRC_OFS_WIN_LEN: len_q <= merge(len_q, wdata_q, wmask) & 32'h0000_3fff;
                `LRC_OFS_TAPS: taps_q <= merge(taps_q, wdata_q, wmask) & 32'h0000_000f;
                `LRC_OFS_LINK_CLK: lclk_q <= merge(lclk_q, wdata_q, wmask);
                `LRC_OFS_LINE_PERIOD: period_q <= merge(period_q, wdata_q, wmask);
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= 2'h0;
        end else if (do_wr) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_mapped ? 2'h0 : 2'h2;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // window segmentation
    logic [15:0] win_s, win_e, pad, seg_max;
    logic [15:0] seg_cnt [SEGS];
    assign win_s = start_q[12:0] == 13'h0 ? 16'h0000 : 16'(start_q[12:0] - 13'h1);
    assign win_e = win_s + len_q[15:0];
    assign pad = ctrl.stamp_en ? `LRC_STAMP_PAD : 16'h0000;

    for (genvar k = 0; k < SEGS; k++) begin : g_seg
        logic [15:0] lo, hi, a, b;
        assign lo = 16'(k) * `LRC_SEG_PIXELS;
        assign hi = lo + `LRC_SEG_PIXELS;
        assign a = win_s > lo ? win_s : lo;
        assign b = win_e < hi ? win_e : hi;
        assign seg_cnt[k] = b > a ? b - a : 16'h0000;
    end

    always_comb begin
        seg_max = 16'h0000;
        for (int k = 0; k < SEGS; k++) begin
            if (seg_cnt[k] > seg_max) begin
                seg_max = seg_cnt[k];
            end
        end
    end

    // operands of each step
    logic paired;
    logic [31:0] rd_num, tx_num, min_rate, num, den;
    logic [35:0] tx_prod;
    assign paired = ctrl.line_mode == `LRC_MODE_PAIRED;
    // doubled rate still fits in 32 bits, top bit of the concatenation is zero
    assign rd_num = paired ? 32'({`LRC_READOUT_RATE, 1'b0}) : `LRC_READOUT_RATE;
    assign tx_prod = lclk_q * taps_q[3:0];
    assign tx_num = tx_prod[31:0];
    assign min_rate = lim_q[0] < lim_q[1] ? (lim_q[0] < lim_q[2] ? (lim_q[0] < lim_q[3] ? lim_q[0] : lim_q[3])
        : (lim_q[2] < lim_q[3] ? lim_q[2] : lim_q[3])) : (lim_q[1] < lim_q[2] ? (lim_q[1] < lim_q[3] ? lim_q[1]
        : lim_q[3]) : (lim_q[2] < lim_q[3] ? lim_q[2] : lim_q[3]));
    assign num = state_q == S_RD ? rd_num : state_q == S_PROC ? PIXEL_PROCESSING_RATE : state_q == S_TX ? tx_num
        : `LRC_NS_PER_S;
    assign den = state_q == S_EXP ? exp_q + `LRC_EXP_OVERHEAD_NS
        : state_q == S_RD ? {16'h0000, seg_max + `LRC_READOUT_OVH}
        : state_q == S_PROC ? {16'h0000, len_q[15:0] + pad}
        : state_q == S_TX ? {16'h0000, 16'(`LRC_TX_TAP_OVH * taps_q[3:0]) + len_q[15:0] + pad}
        : min_rate;

    logic div_start, div_busy, div_done;
    logic [31:0] quot;
    assign div_start = state_q != S_IDLE && !issued_q && !div_busy;

    lrc_divider #(.W(32)) u_div (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(div_start),
        .num_i(num),
        .den_i(den),
        .busy_o(div_busy),
        .done_o(div_done),
        .quot_o(quot)
    );

    logic launch;
    assign launch = state_q == S_IDLE && dirty_q;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= S_IDLE;
            dirty_q <= 1'b1;
            issued_q <= 1'b0;
        end else begin
            // a setting written during a clear still counts
            dirty_q <= wr_hit_cfg || (dirty_q && !launch);
            issued_q <= div_done ? 1'b0 : (issued_q || div_start);
            unique case (state_q)
                S_IDLE: state_q <= launch ? S_EXP : S_IDLE;
                S_EXP: state_q <= div_done ? S_RD : S_EXP;
                S_RD: state_q <= div_done ? S_PROC : S_RD;
                S_PROC: state_q <= div_done ? S_TX : S_PROC;
                S_TX: state_q <= div_done ? S_PER : S_TX;
                S_PER: state_q <= div_done ? S_IDLE : S_PER;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < 4; i++) begin
                lim_q[i] <= 32'h0000_0000;
            end
            period_min_q <= 32'h0000_0000;
            rate_q <= 32'h0000_0000;
            valid_q <= 1'b0;
        end else if (div_done) begin
            if (state_q == S_PER) begin
                // old result stays readable until the whole chain is done
                period_min_q <= quot;
                rate_q <= min_rate;
                valid_q <= 1'b1;
            end else begin
                lim_q[state_q[1:0] - 2'h1] <= quot;
            end
        end
    end

    // free-run line generator, counts in ns
    logic [31:0] run_ns_q, run_next;
    assign run_next = run_ns_q + `LRC_CLK_PERIOD_NS;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            run_ns_q <= 32'h0000_0000;
            LINE_START_O <= 1'b0;
        end else if (ctrl.ext_sync || period_q == 32'h0000_0000) begin
            run_ns_q <= 32'h0000_0000;
            LINE_START_O <= 1'b0;
        end else begin
            LINE_START_O <= run_next >= period_q;
            run_ns_q <= run_next >= period_q ? 32'h0000_0000 : run_next;
        end
    end

    // read channel
    logic [31:0] rd_mux;
    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
    assign rd_mux = S_AXI_ARADDR_I == `LRC_OFS_CTRL ? ctrl_q
        : S_AXI_ARADDR_I == `LRC_OFS_EXPOSURE ? exp_q
        : S_AXI_ARADDR_I == `LRC_OFS_WIN_START ? start_q
        : S_AXI_ARADDR_I == `LRC_OFS_WIN_LEN ? len_q
        : S_AXI_ARADDR_I == `LRC_OFS_TAPS ? taps_q
        : S_AXI_ARADDR_I == `LRC_OFS_LINK_CLK ? lclk_q
        : S_AXI_ARADDR_I == `LRC_OFS_LINE_PERIOD ? period_q
        : S_AXI_ARADDR_I == `LRC_OFS_PERIOD_MIN ? (ctrl.ext_sync ? 32'h0000_0000 : period_min_q)
        : S_AXI_ARADDR_I == `LRC_OFS_MAX_RATE ? (ctrl.ext_sync ? 32'h0000_0000 : rate_q)
        : S_AXI_ARADDR_I == `LRC_OFS_STATUS ? {30'h0, valid_q, state_q != S_IDLE || dirty_q}
        : 32'h0000_0000;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= 2'h0;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= rd_mux;
            S_AXI_RRESP_O <= rd_mapped ? 2'h0 : 2'h2;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end

    sequence s_calc_done;
        state_q == S_PER && div_done;
    endsequence

    property p_pad;
        @(posedge CLK_I) disable iff (!RST_B_I) ctrl.stamp_en |-> pad == 16'h0010;
    endproperty
    a_pad: assert property (p_pad) else $error("stamp padding not 16");

    property p_factor;
        @(posedge CLK_I) disable iff (!RST_B_I) !paired |-> rd_num == 32'h0989_6800;
    endproperty
    a_factor: assert property (p_factor) else $error("readout factor wrong");

    property p_seg_bound;
        @(posedge CLK_I) disable iff (!RST_B_I) seg_max <= 16'h0800 && seg_max <= len_q[15:0];
    endproperty
    a_seg_bound: assert property (p_seg_bound) else $error("segment count out of range");

    property p_min_of_four;
        @(posedge CLK_I) disable iff (!RST_B_I)
            s_calc_done |=> rate_q <= lim_q[0] && rate_q <= lim_q[1] && rate_q <= lim_q[2] && rate_q <= lim_q[3];
    endproperty
    a_min_of_four: assert property (p_min_of_four) else $error("rate not the minimum");

    property p_exp_den;
        @(posedge CLK_I) disable iff (!RST_B_I) div_start && state_q == S_EXP |-> den == exp_q + 32'h0000_0514;
    endproperty
    a_exp_den: assert property (p_exp_den) else $error("exposure divisor wrong");

    property p_hold;
        @(posedge CLK_I) disable iff (!RST_B_I) state_q != S_PER |=> $stable(period_min_q);
    endproperty
    a_hold: assert property (p_hold) else $error("period changed mid calculation");

    property p_recompute;
        @(posedge CLK_I) disable iff (!RST_B_I) wr_hit_cfg |-> ##[1:400] s_calc_done;
    endproperty
    a_recompute: assert property (p_recompute) else $error("no recompute after write");

    property p_hidden;
        @(posedge CLK_I) disable iff (!RST_B_I)
            S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 6'h1c && ctrl.ext_sync
            |=> S_AXI_RDATA_O == 32'h0000_0000;
    endproperty
    a_hidden: assert property (p_hidden) else $error("minimum shown under external sync");

    property p_line_pulse;
        @(posedge CLK_I) disable iff (!RST_B_I) LINE_START_O |=> !LINE_START_O;
    endproperty
    a_line_pulse: assert property (p_line_pulse) else $error("line start wider than one cycle");
endmodule

/* core/lrc_defines.svh */
// register offsets, field positions, reset values and constants of the line rate limit calculator
// Function
// - exposure limit is one over exposure time plus 1.3 us overhead.
// - readout limit is 160e6 times mode factor over largest segment count plus 224.
// - mode factor is 2 in paired-row capture mode, otherwise 1.
// - processing limit is pixel processing rate over window length plus padding.
// - padding is 0 without line stamp, 16 with line stamp.
// - transmission limit is link clock times taps over 12 taps plus length plus padding.
// - maximum line rate is the smallest of the four limits.
// - minimum line period is the reciprocal of the maximum line rate.
// - sensor lines split into 2048-pixel segments: one, two or four.
// - largest segment count is window pixels inside the fullest segment.
// - minimum line period is readable in the line period minimum field.
// - minimum period is not shown under external sync; host reads it before.
// - free run produces lines at one over the programmed line period.
`ifndef LRC_DEFINES_SVH
`define LRC_DEFINES_SVH
`define LRC_OFS_CTRL 6'h00
`define LRC_OFS_EXPOSURE 6'h04
`define LRC_OFS_WIN_START 6'h08
`define LRC_OFS_WIN_LEN 6'h0c
`define LRC_OFS_TAPS 6'h10
`define LRC_OFS_LINK_CLK 6'h14
`define LRC_OFS_LINE_PERIOD 6'h18
`define LRC_OFS_PERIOD_MIN 6'h1c
`define LRC_OFS_MAX_RATE 6'h20
`define LRC_OFS_STATUS 6'h24
`define LRC_CTRL_STAMP_BIT 0
`define LRC_CTRL_EXT_BIT 1
`define LRC_CTRL_MODE_LSB 2
`define LRC_RST_CTRL 32'h0000_0000
`define LRC_RST_EXPOSURE 32'h0000_0fa0
`define LRC_RST_WIN_START 32'h0000_0001
`define LRC_RST_WIN_LEN 32'h0000_0800
`define LRC_RST_TAPS 32'h0000_0008
`define LRC_RST_LINK_CLK 32'h04c4_b400
`define LRC_RST_LINE_PERIOD 32'h0000_2710
`define LRC_MODE_PAIRED 3'h1
`define LRC_EXP_OVERHEAD_NS 32'h0000_0514
`define LRC_NS_PER_S 32'h3b9a_ca00
`define LRC_READOUT_RATE 32'h0989_6800
`define LRC_READOUT_OVH 16'h00e0
`define LRC_SEG_PIXELS 16'h0800
`define LRC_STAMP_PAD 16'h0010
`define LRC_TX_TAP_OVH 16'h000c
`define LRC_CLK_PERIOD_NS 32'h0000_0014
`endif

/* core/lrc_pkg.sv */
// types shared by the line rate limit calculator
package lrc_pkg;
    typedef struct packed {
        logic [2:0] line_mode;
        logic ext_sync;
        logic stamp_en;
    } lrc_ctrl_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_EXP = 3'b001,
        S_RD = 3'b010,
        S_PROC = 3'b011,
        S_TX = 3'b100,
        S_PER = 3'b101
    } lrc_state_t;
    typedef logic [1:0] lrc_resp_t;
endpackage

/* core/lrc_divider.sv */
// serial restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module lrc_divider #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [W-1:0] num_i,
    input wire logic [W-1:0] den_i,
    output logic busy_o,
    output logic done_o,
    output logic [W-1:0] quot_o
);
    logic [W:0] rem_q;
    logic [W-1:0] q_q;
    logic [W-1:0] den_q;
    logic [7:0] cnt_q;
    logic [W:0] shifted;
    logic [W:0] trial;
    logic fits;
    logic [W-1:0] q_next;

    assign shifted = {rem_q[W-1:0], q_q[W-1]};
    assign trial = shifted - {1'b0, den_q};
    // zero divisor always fits, so it saturates to all ones
    assign fits = !trial[W];
    assign q_next = {q_q[W-2:0], fits};
    assign busy_o = cnt_q != 8'h00;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rem_q <= '0;
            q_q <= '0;
            den_q <= '0;
            cnt_q <= 8'h00;
            done_o <= 1'b0;
            quot_o <= '0;
        end else begin
            done_o <= busy_o && cnt_q == 8'h01;
            if (start_i && !busy_o) begin
                rem_q <= '0;
                q_q <= num_i;
                den_q <= den_i;
                cnt_q <= 8'(W);
            end else if (busy_o) begin
                rem_q <= fits ? trial : shifted;
                q_q <= q_next;
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    quot_o <= q_next;
                end
            end
        end
    end
endmodule

/* sim/lrc_top_tb_top.sv */
// self-checking bench for the line rate limit calculator
`timescale 1ns/100ps
`include "lrc_defines.svh"
module lrc_top_tb_top;
    import lrc_pkg::*;
    localparam int SEGS = 2;
    localparam longint PROC_RATE = 640000000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [5:0] araddr = 6'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, line_start;
    lrc_resp_t bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0;
    int checks_done = 0;
    logic [33:0] rq[$];
    lrc_resp_t bq[$];
    longint cur_per, cur_rate;

    lrc_top #(.SEGS(SEGS), .PIXEL_PROCESSING_RATE(32'(PROC_RATE))) u_dut (
        .CLK_I(clk), .RST_B_I(rst_b),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .LINE_START_O(line_start)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // handshake decided at the falling edge so it never races the slave's own update
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input lrc_resp_t er);
        logic aw_t, w_t, b_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        b_t = 1'b0;
        bq.push_back(er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t) begin
            @(negedge clk);
            aw_t = aw_t | (awvalid && awready === 1'b1);
            w_t = w_t | (wvalid && wready === 1'b1);
            b_t = (bvalid === 1'b1);
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] ed, input lrc_resp_t er);
        logic ar_t, r_t;
        ar_t = 1'b0;
        r_t = 1'b0;
        rq.push_back({er, ed});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t) begin
            @(negedge clk);
            ar_t = ar_t | (arvalid && arready === 1'b1);
            r_t = (rvalid === 1'b1);
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) rready <= 1'b0;
        end
    endtask

    // expected limits worked out independently, integer truncation as the divider does
    function automatic longint mrate(input longint ex, md, st, ln, sp, tp, ck);
        longint pad, ms, lo, a, b, e, r, p, t, m;
        int s;
        pad = sp ? 16 : 0;
        ms = 0;
        for (s = 0; s < SEGS; s++) begin
            lo = s * 2048 + 1;
            a = (st > lo) ? st : lo;
            b = (st + ln - 1 < lo + 2047) ? st + ln - 1 : lo + 2047;
            if (b >= a && b - a + 1 > ms) ms = b - a + 1;
        end
        e = 1000000000 / (ex + 1300);
        r = 160000000 * ((md == 1) ? 2 : 1) / (ms + 224);
        p = PROC_RATE / (ln + pad);
        t = ck * tp / (12 * tp + ln + pad);
        m = e;
        if (r < m) m = r;
        if (p < m) m = p;
        if (t < m) m = t;
        return m;
    endfunction

    task automatic results(input longint ex, md, st, ln, sp, tp, ck);
        cur_rate = mrate(ex, md, st, ln, sp, tp, ck);
        cur_per = 1000000000 / cur_rate;
        rd(`LRC_OFS_STATUS, 32'h2, 2'h0);
        rd(`LRC_OFS_PERIOD_MIN, 32'(cur_per), 2'h0);
        rd(`LRC_OFS_MAX_RATE, 32'(cur_rate), 2'h0);
    endtask

    task automatic cfg(input longint ex, md, st, ln, sp, tp, ck);
        wr(`LRC_OFS_CTRL, {27'h0, 3'(md), 1'b0, 1'(sp)}, 2'h0);
        wr(`LRC_OFS_EXPOSURE, 32'(ex), 2'h0);
        wr(`LRC_OFS_WIN_START, 32'(st), 2'h0);
        wr(`LRC_OFS_WIN_LEN, 32'(ln), 2'h0);
        wr(`LRC_OFS_TAPS, 32'(tp), 2'h0);
        wr(`LRC_OFS_LINK_CLK, 32'(ck), 2'h0);
        // a write mid-chain reruns it, so allow two full chains
        repeat (500) @(posedge clk);
        results(ex, md, st, ln, sp, tp, ck);
    endtask

    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1 && bready && bq.size() > 0) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        int i, cnt;
        longint st, ln, sp, tp, ck;
        cnt = $urandom(32'h0750);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (500) @(posedge clk);
        rd(`LRC_OFS_CTRL, `LRC_RST_CTRL, 2'h0);
        rd(`LRC_OFS_EXPOSURE, `LRC_RST_EXPOSURE, 2'h0);
        rd(`LRC_OFS_WIN_START, `LRC_RST_WIN_START, 2'h0);
        rd(`LRC_OFS_WIN_LEN, `LRC_RST_WIN_LEN, 2'h0);
        rd(`LRC_OFS_TAPS, `LRC_RST_TAPS, 2'h0);
        rd(`LRC_OFS_LINK_CLK, `LRC_RST_LINK_CLK, 2'h0);
        rd(`LRC_OFS_LINE_PERIOD, `LRC_RST_LINE_PERIOD, 2'h0);
        results(4000, 0, 1, 2048, 0, 8, 80000000);
        // paired-row example, readout term wins
        cfg(4000, 1, 1249, 2400, 0, 8, 80000000);
        rd(`LRC_OFS_PERIOD_MIN, 32'd5700, 2'h0);
        rd(`LRC_OFS_MAX_RATE, 32'd175438, 2'h0);
        // window straddling the segment seam
        cfg(100, 0, 1985, 256, 1, 4, 40000000);
        for (i = 0; i < 8; i++) begin
            st = 1 + $urandom % 4000;
            ln = 1 + $urandom % (4097 - st);
            // paired-row capture gets a centred window
            if (i == 1) st = 1 + (4096 - ln) / 2;
            sp = $urandom % 2;
            tp = 1 + $urandom % 15;
            ck = 20000000 + $urandom % 60000000;
            cfg($urandom % 200000, i, st, ln, sp, tp, ck);
        end
        // back-to-back setting change while a chain runs
        wr(`LRC_OFS_EXPOSURE, 32'd1000000, 2'h0);
        wr(`LRC_OFS_EXPOSURE, 32'd2000, 2'h0);
        repeat (500) @(posedge clk);
        results(2000, 7, st, ln, sp, tp, ck);
        wr(`LRC_OFS_CTRL, 32'h2, 2'h0);
        repeat (500) @(posedge clk);
        rd(`LRC_OFS_PERIOD_MIN, 32'h0, 2'h0);
        rd(`LRC_OFS_MAX_RATE, 32'h0, 2'h0);
        cnt = 0;
        for (i = 0; i < 600; i++) begin
            @(negedge clk);
            cnt += (line_start === 1'b1);
        end
        chk(34'(cnt), 34'h0);
        wr(`LRC_OFS_LINE_PERIOD, 32'd200, 2'h0);
        wr(`LRC_OFS_CTRL, 32'h0, 2'h0);
        repeat (500) @(posedge clk);
        // look only at falling edges, never in the launching time step
        do @(negedge clk); while (line_start !== 1'b1);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (line_start !== 1'b1);
        chk(34'(cnt), 34'd10);
        // refused and read-only places
        wr(6'h28, 32'h1234_5678, 2'h2);
        wr(6'h02, 32'h1, 2'h2);
        rd(6'h28, 32'h0, 2'h2);
        wr(`LRC_OFS_MAX_RATE, 32'h5, 2'h0);
        // single byte lane into the window length
        wstrb <= 4'h1;
        wr(`LRC_OFS_WIN_LEN, 32'hffff_ff40, 2'h0);
        wstrb <= 4'hf;
        rd(`LRC_OFS_WIN_LEN, 32'(((ln & 32'hffff_ff00) | 32'h40) & 32'h3fff), 2'h0);
        rd(`LRC_OFS_CTRL, 32'h0, 2'h0);
        conclude();
    end
endmodule
